// >>> hw/hdv_divider.v
`include "hdv_consts.vh"

module hdv_divider (
  // clock, asynchronous active-low reset and global freeze
  input wire mclk,
  input wire nrst,
  input wire clk_en,
  // access port from the processor side
  input wire acc_valid,
  input wire acc_write,
  input wire [2:0] acc_sel,
  input wire [31:0] acc_wdata,
  // taken strobe and registered read data
  output wire acc_ready,
  output reg [31:0] acc_rdata,
  // status seen from outside
  output wire busy,
  output wire div_done,
  output wire div_by_zero
);

  // state codes, one-hot
  // idle waits for a start; run counts the latency
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN = 2'b10;

  // stored operands and mode
  // dividend, loaded by software before the start
  reg [31:0] dividend_reg;
  // divisor, loaded by the start write itself
  reg [31:0] divisor_reg;
  // high selects two's-complement operands
  reg signed_reg;
  // results, held until the next division ends
  // quotient word
  reg [31:0] quot_reg;
  // remainder word
  reg [31:0] rem_reg;
  // flags, held until the next start
  // last division finished
  reg done_reg;
  // last divisor was zero
  reg dz_reg;
  // sequencing
  // one-hot state
  reg [1:0] state_reg;
  // cycles left in the running division
  reg [3:0] count_reg;

  // absolute value of a word, in signed mode only
  // a negative word is negated; the most negative word maps onto itself,
  // which still reads correctly as an unsigned magnitude
  function [31:0] mag;
    input [31:0] v;
    input sgn;
    begin
      mag = (sgn && v[31]) ? (~v + 32'h0000_0001) : v;
    end
  endfunction

  // conditional two's-complement negate
  // used to put the sign back on quotient and remainder
  function [31:0] neg_if;
    input [31:0] v;
    input n;
    begin
      neg_if = n ? (~v + 32'h0000_0001) : v;
    end
  endfunction

  // combinational result from the held operands
  // the operands cannot change while running, so the value is settled
  // long before the sequencer captures it
  // operand magnitudes
  reg [31:0] a_mag;
  reg [31:0] b_mag;
  // result magnitudes
  reg [31:0] q_mag;
  reg [31:0] r_mag;
  // signed results
  reg [31:0] q_next;
  reg [31:0] r_next;
  always @* begin
    // defaults keep every path assigned
    a_mag = mag(dividend_reg, signed_reg);
    b_mag = mag(divisor_reg, signed_reg);
    q_mag = 32'h0000_0000;
    r_mag = 32'h0000_0000;
    q_next = 32'h0000_0000;
    r_next = 32'h0000_0000;
    // zero divisor result
    // both results forced to zero; no division is attempted
    if (divisor_reg == 32'h0000_0000) begin
      q_next = 32'h0000_0000;
      r_next = 32'h0000_0000;
    end else begin
      q_mag = a_mag / b_mag;
      r_mag = a_mag % b_mag;
      // sign fix-up on magnitudes
      // quotient negative when signs differ, remainder takes dividend sign
      q_next = neg_if(q_mag, signed_reg && (dividend_reg[31] ^ divisor_reg[31]));
      r_next = neg_if(r_mag, signed_reg && dividend_reg[31]);
    end
  end

  // access decode
  // a write and a read are told apart by acc_write
  wire wr = acc_valid && acc_write;
  wire rd = acc_valid && !acc_write;
  // quotient or remainder selected
  wire res_sel = (acc_sel == `HDV_SEL_QUOTIENT) || (acc_sel == `HDV_SEL_REMAINDER);
  // division under way
  wire running = (state_reg == ST_RUN);
  // divisor write is the start
  // ignored while running: the master is stalled instead
  wire start = clk_en && wr && (acc_sel == `HDV_SEL_DIVISOR) && !running;

  // result reads wait; all writes also wait while running
  // a stalled access is not lost: the master keeps it up until taken
  // a frozen block takes nothing
  assign acc_ready = clk_en && !(running && (rd ? res_sel : 1'b1));
  // status outputs straight from state and flags
  assign busy = running;
  assign div_done = done_reg;
  assign div_by_zero = dz_reg;

  // sequencer, operands and results
  // everything holds still while clk_en is low
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // idle, flags clear, operands and results zero
      state_reg <= ST_IDLE;
      count_reg <= `HDV_RST_COUNT;
      dividend_reg <= `HDV_RST_WORD;
      divisor_reg <= `HDV_RST_WORD;
      signed_reg <= 1'b0;
      quot_reg <= `HDV_RST_WORD;
      rem_reg <= `HDV_RST_WORD;
      done_reg <= 1'b0;
      dz_reg <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        ST_IDLE: begin
          // idle: operand and mode writes land, divisor write starts
          // operand writes
          if (wr && acc_sel == `HDV_SEL_DIVIDEND) begin
            dividend_reg <= acc_wdata;
          end
          if (wr && acc_sel == `HDV_SEL_CONTROL) begin
            signed_reg <= acc_wdata[`HDV_CTRL_SIGNED_BIT];
          end
          if (start) begin
            divisor_reg <= acc_wdata;
            done_reg <= 1'b0;
            dz_reg <= (acc_wdata == 32'h0000_0000);
            // a full latency count: done shows after the eighth edge
            count_reg <= `HDV_LATENCY;
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          // count out the latency
          // the last count captures results and returns to idle
          if (count_reg == 4'h1) begin
            quot_reg <= q_next;
            rem_reg <= r_next;
            done_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
          // step the counter down; it rests at zero when idle
          count_reg <= count_reg - 4'h1;
        end
        default: begin
          // illegal code: recover to idle
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // read data register
  // loaded only on a taken read, so it holds between reads
  // a stalled result read waits in acc_ready, not here
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_rdata <= `HDV_RST_WORD;
    end else if (clk_en && rd && acc_ready) begin
      // pick the selected word
      case (acc_sel)
        // operands read back as written
        `HDV_SEL_DIVIDEND: acc_rdata <= dividend_reg;
        `HDV_SEL_DIVISOR: acc_rdata <= divisor_reg;
        // results of the last finished division
        `HDV_SEL_QUOTIENT: acc_rdata <= quot_reg;
        // remainder follows the quotient
        `HDV_SEL_REMAINDER: acc_rdata <= rem_reg;
        `HDV_SEL_STATUS: begin
          acc_rdata <= {30'h0000_0000, dz_reg, done_reg};
        end
        // mode word
        `HDV_SEL_CONTROL: acc_rdata <= {31'h0000_0000, signed_reg};
        // unmapped codes read as zero
        default: acc_rdata <= `HDV_RST_WORD;
      endcase
    end
  end

endmodule // hdv_divider

// >>> hw/hdv_consts.vh
`ifndef HDV_CONSTS_VH
`define HDV_CONSTS_VH
// operand and result width
`define HDV_WIDTH 32
// local register select codes on the access port
`define HDV_SEL_DIVIDEND 3'h0
`define HDV_SEL_DIVISOR 3'h1
`define HDV_SEL_QUOTIENT 3'h2
`define HDV_SEL_REMAINDER 3'h3
`define HDV_SEL_STATUS 3'h4
`define HDV_SEL_CONTROL 3'h5
// status word bit positions
`define HDV_STAT_DONE_BIT 0
`define HDV_STAT_DIVZERO_BIT 1
// control word bit position
`define HDV_CTRL_SIGNED_BIT 0
// division latency, in cycles from the start write
`define HDV_LATENCY 4'h8
// reset values
`define HDV_RST_WORD 32'h0000_0000
`define HDV_RST_COUNT 4'h0
`endif

// >>> tb/hdv_props.sv
module hdv_props(
  input wire mclk, nrst, clk_en, acc_valid, acc_write, acc_ready, busy, div_done, div_by_zero,
  input wire [2:0] acc_sel,
  input wire [31:0] acc_wdata, acc_rdata);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // taken start and taken read
  wire st = acc_valid && acc_write && acc_sel == 3'h1 && acc_ready;
  wire rd = acc_valid && !acc_write && acc_ready;
  // eight busy cycles, then idle with done set
  sequence s_run;
    busy [*8] ##1 (!busy && div_done);
  endsequence
  AST_LAT: assert property (
    disable iff (!nrst || !clk_en) st |=> s_run) else $error("latency");
  AST_FRZ: assert property (!clk_en |=> $stable(busy) && $stable(div_done)
    && $stable(div_by_zero) && $stable(acc_rdata)) else $error("freeze moved");
  AST_FRZ_RDY: assert property (!clk_en |-> !acc_ready) else $error("frozen taken");
  AST_ZERO: assert property (st |=> div_by_zero == ($past(acc_wdata) == 32'h0))
    else $error("zero flag");
  AST_STALL: assert property (busy && acc_valid && (acc_write || acc_sel[2:1] == 2'h1)
    |-> !acc_ready) else $error("stall");
  AST_IDLE: assert property (!busy && acc_valid |-> acc_ready == clk_en)
    else $error("idle refused");
  AST_HOLD: assert property (div_done && !st |=> div_done) else $error("done lost");
  AST_DONE: assert property (div_done |-> !busy) else $error("done busy");
  AST_RD: assert property (!rd |=> $stable(acc_rdata)) else $error("rdata");
  AST_SRC: assert property ($rose(busy) |-> $past(st)) else $error("start");
endmodule // hdv_props

// >>> tb/hdv_cpu.sv
module hdv_cpu(
  input wire mclk, acc_ready,
  input wire [31:0] acc_rdata,
  output logic acc_valid = 0, acc_write = 0,
  output logic [2:0] acc_sel = 3'h0,
  output logic [31:0] acc_wdata = 32'h0);
  timeunit 1ns;
  timeprecision 1ps;
  // sticky flag: a request was never taken
  bit tmo = 0;
  // hold the request until taken, then release and pick up the answer
  task automatic acc(logic w, logic [2:0] s, logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(negedge mclk);
    {acc_valid, acc_write, acc_sel, acc_wdata} = {1'b1, w, s, d};
    while (!acc_ready && n < 40) @(negedge mclk) n++;
    tmo |= n > 39;
    @(negedge mclk);
    acc_valid = 0;
    acc_wdata = ~d;
    r = acc_rdata;
  endtask
endmodule // hdv_cpu

// >>> tb/hdv_divider_tb.sv
module hdv_divider_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, nrst = 0, clk_en = 1, acc_valid, acc_write, acc_ready, busy;
  logic div_done, div_by_zero;
  logic [2:0] acc_sel;
  logic [31:0] acc_wdata, acc_rdata, q, r, v;
  int bad_count = 0, cmp_count = 0;
  // 200 MHz clock
  always #2.5 mclk = ~mclk;
  hdv_divider i_hdv_divider(.*);
  hdv_cpu i_hdv_cpu(.*);
  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // read one register and compare; a stuck request ends the run
  task chk(logic [2:0] s, logic [31:0] e);
    i_hdv_cpu.acc(0, s, 32'h0, v);
    cmp_count++;
    if (v !== e || i_hdv_cpu.tmo) bad_count++;
    if (v !== e) $display("mismatch reg%0d exp %h seen %h", s, e, v);
    if (i_hdv_cpu.tmo) report_and_stop;
  endtask
  // one division against the reference model
  task div(logic [31:0] x, logic [31:0] y, logic m, int frz);
    {q, r} = 64'h0;
    if (y && m) {q, r} = {$signed(x) / $signed(y), $signed(x) % $signed(y)};
    else if (y) {q, r} = {x / y, x % y};
    i_hdv_cpu.acc(1, 3'h0, x, v);
    i_hdv_cpu.acc(1, 3'h5, {31'h0, m}, v);
    i_hdv_cpu.acc(1, 3'h1, y, v);
    // freeze part-way: nothing may move while clk_en is low
    if (frz > 0) begin
      clk_en = 0;
      repeat (frz) @(negedge mclk);
      clk_en = 1;
    end
    chk(3'h2, q);
    chk(3'h3, r);
    chk(3'h4, {30'h0, y == 32'h0, 1'b1});
  endtask
  initial begin
    v = $urandom(27);
    repeat (8) @(posedge mclk);
    @(negedge mclk) nrst = 1;
    chk(3'h6, 32'h0);
    for (int k = 0; k < 30; k++)
      div($urandom, k % 5 ? {32{k[1]}} ^ ($urandom >> k) : 32'h0, k[0], k % 7 == 3 ? 12 : 0);
    // reset in mid-division: flags and quotient return to zero
    i_hdv_cpu.acc(1, 3'h0, 32'h0000_0064, v);
    i_hdv_cpu.acc(1, 3'h1, 32'h0000_0007, v);
    @(negedge mclk) nrst = 0;
    repeat (3) @(negedge mclk);
    nrst = 1;
    chk(3'h4, 32'h0);
    chk(3'h2, 32'h0);
    report_and_stop;
  end
endmodule // hdv_divider_tb
bind hdv_divider hdv_props i_hdv_props(.*);
